// >>> core/dpram_pkg.sv
// constants shared by the dual-port ram core and its storage array
// assumes one system clock that samples both host ports as plain pins
package dpram_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int DEPTH = 32'h0001_0000;
    localparam int DEPTH_SMALL = 32'h0000_8000;
    // layout of the sampled pin vector of one port
    localparam int PIN_CLK = 0;
    localparam int PIN_CE_N = 1;
    localparam int PIN_CE = 2;
    localparam int PIN_RW = 3;
    localparam int PIN_OE_N = 4;
    localparam int PIN_STROBE_N = 5;
    localparam int PIN_ADVANCE_N = 6;
    localparam int PIN_CLEAR_N = 7;
    localparam int PIN_LAT = 8;
    localparam int PIN_ADDR_LSB = 9;
    localparam int PIN_DATA_LSB = 25;
    localparam int PIN_W = 33;
    localparam logic [15:0] ADDR_ZERO = 16'h0000;
    localparam logic [15:0] ADDR_STEP = 16'h0001;
    localparam logic [7:0] DATA_ZERO = 8'h00;
endpackage

// >>> core/dpram_array.sv
// storage array with two independent ports and registered read data
// assumes write enables are single-cycle pulses from the port logic
`timescale 1ns/1ps
module dpram_array (
    input wire logic i_ref_clk,
    input wire logic i_clk_en,
    input wire logic [1:0] i_we,
    input wire logic [1:0][15:0] i_addr,
    input wire logic [1:0][7:0] i_wdata,
    output logic [1:0][7:0] o_rdata
);
    logic [7:0] mem [0:dpram_pkg::DEPTH-1];

    // one process holds every write; on a same-cell clash the right port lands last
    always_ff @(posedge i_ref_clk) begin
        if (i_clk_en) begin
            if (i_we[0]) begin
                mem[i_addr[0]] <= i_wdata[0];
            end
            if (i_we[1]) begin
                mem[i_addr[1]] <= i_wdata[1];
            end
            o_rdata[0] <= mem[i_addr[0]];
            o_rdata[1] <= mem[i_addr[1]];
        end
    end
endmodule

// >>> core/dpram_core.sv
// synchronous dual-port ram, each host port sampled as pins on one system clock
// assumes the system clock runs well above either port clock (at least 8x)
`timescale 1ns/1ps
module dpram_core (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic i_left_port_clock,
    input wire logic i_left_chip_enable_active_low,
    input wire logic i_left_chip_enable_active_high,
    input wire logic i_left_read_not_write,
    input wire logic i_left_output_enable_n,
    input wire logic i_left_address_strobe_n,
    input wire logic i_left_counter_advance_n,
    input wire logic i_left_counter_clear_n,
    input wire logic i_left_output_latency_select,
    input wire logic [15:0] i_left_address,
    input wire logic [7:0] i_left_data,
    output logic [7:0] o_left_data,
    output logic o_left_data_oe_n,
    input wire logic i_right_port_clock,
    input wire logic i_right_chip_enable_active_low,
    input wire logic i_right_chip_enable_active_high,
    input wire logic i_right_read_not_write,
    input wire logic i_right_output_enable_n,
    input wire logic i_right_address_strobe_n,
    input wire logic i_right_counter_advance_n,
    input wire logic i_right_counter_clear_n,
    input wire logic i_right_output_latency_select,
    input wire logic [15:0] i_right_address,
    input wire logic [7:0] i_right_data,
    output logic [7:0] o_right_data,
    output logic o_right_data_oe_n
);
    typedef struct packed {
        logic [dpram_pkg::PIN_W-1:0] s1;
        logic [dpram_pkg::PIN_W-1:0] s2;
        logic [dpram_pkg::PIN_W-1:0] s3;
        logic clk_level;
        logic [15:0] addr;
        logic lat;
        logic rd_pend;
        logic rd_valid;
        logic [7:0] hold;
        logic [7:0] dout;
        logic drive;
        logic oe_n;
    } port_state_type;

    typedef struct packed {
        port_state_type [1:0] p;
    } core_state_type;

    core_state_type st_reg;
    core_state_type st_next;
    logic [1:0][dpram_pkg::PIN_W-1:0] pins;
    logic [1:0] port_edge;
    logic [1:0] mem_we;
    logic [1:0][15:0] mem_addr;
    logic [1:0][7:0] mem_wdata;
    logic [1:0][7:0] mem_rdata;

    // clear beats strobe, strobe beats advance; none looks at the chip enables
    function automatic logic [15:0] next_addr(input logic [dpram_pkg::PIN_W-1:0] in,
                                              input logic [15:0] cur);
        logic [15:0] res;
        res = cur;
        if (!in[dpram_pkg::PIN_CLEAR_N]) begin
            res = dpram_pkg::ADDR_ZERO;
        end else if (!in[dpram_pkg::PIN_STROBE_N]) begin
            res = in[dpram_pkg::PIN_ADDR_LSB +: 16];
        end else if (!in[dpram_pkg::PIN_ADVANCE_N]) begin
            res = 16'(cur + dpram_pkg::ADDR_STEP);
        end
        return res;
    endfunction

    assign pins[0] = {i_left_data, i_left_address, i_left_output_latency_select,
        i_left_counter_clear_n, i_left_counter_advance_n, i_left_address_strobe_n,
        i_left_output_enable_n, i_left_read_not_write, i_left_chip_enable_active_high,
        i_left_chip_enable_active_low, i_left_port_clock};
    assign pins[1] = {i_right_data, i_right_address, i_right_output_latency_select,
        i_right_counter_clear_n, i_right_counter_advance_n, i_right_address_strobe_n,
        i_right_output_enable_n, i_right_read_not_write, i_right_chip_enable_active_high,
        i_right_chip_enable_active_low, i_right_port_clock};

    always_comb begin
        logic [dpram_pkg::PIN_W-1:0] in;
        logic sel;
        logic rd;
        in = '0;
        sel = 1'b0;
        rd = 1'b0;
        st_next = st_reg;
        port_edge = 2'b00;
        mem_we = 2'b00;
        mem_addr = '0;
        mem_wdata = '0;
        for (int i = 0; i < 2; i++) begin
            // the first stage feeds only the second
            st_next.p[i].s1 = pins[i];
            st_next.p[i].s2 = st_reg.p[i].s1;
            st_next.p[i].s3 = st_reg.p[i].s2;
            in = st_reg.p[i].s3;
            if (st_reg.p[i].s2[dpram_pkg::PIN_CLK] == st_reg.p[i].s3[dpram_pkg::PIN_CLK]) begin
                st_next.p[i].clk_level = st_reg.p[i].s3[dpram_pkg::PIN_CLK];
            end
            port_edge[i] = st_reg.p[i].s2[dpram_pkg::PIN_CLK]
                & st_reg.p[i].s3[dpram_pkg::PIN_CLK] & ~st_reg.p[i].clk_level;
            mem_addr[i] = st_reg.p[i].addr;
            mem_wdata[i] = in[dpram_pkg::PIN_DATA_LSB +: 8];
            st_next.p[i].rd_pend = 1'b0;
            if (port_edge[i]) begin
                st_next.p[i].addr = next_addr(in, st_reg.p[i].addr);
                mem_addr[i] = st_next.p[i].addr;
                sel = ~in[dpram_pkg::PIN_CE_N] & in[dpram_pkg::PIN_CE];
                rd = sel & in[dpram_pkg::PIN_RW];
                mem_we[i] = sel & ~in[dpram_pkg::PIN_RW];
                st_next.p[i].lat = in[dpram_pkg::PIN_LAT];
                st_next.p[i].rd_pend = rd;
                st_next.p[i].rd_valid = rd;
                if (in[dpram_pkg::PIN_LAT]) begin
                    // second enable stage: deselect lands one port cycle late
                    st_next.p[i].dout = st_reg.p[i].hold;
                    st_next.p[i].drive = st_reg.p[i].rd_valid;
                end else if (!rd) begin
                    st_next.p[i].drive = 1'b0;
                end
            end
            if (st_reg.p[i].rd_pend) begin
                st_next.p[i].hold = mem_rdata[i];
                if (!st_reg.p[i].lat) begin
                    st_next.p[i].dout = mem_rdata[i];
                    st_next.p[i].drive = 1'b1;
                end
            end
            // output enable is sampled every system cycle, not at port edges
            st_next.p[i].oe_n = ~(st_next.p[i].drive & ~in[dpram_pkg::PIN_OE_N]);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            st_reg <= '0;
            st_reg.p[0].oe_n <= 1'b1;
            st_reg.p[1].oe_n <= 1'b1;
        end else if (i_clk_en) begin
            st_reg <= st_next;
        end
    end

    dpram_array u_array (
        .i_ref_clk(i_ref_clk),
        .i_clk_en(i_clk_en),
        .i_we(mem_we),
        .i_addr(mem_addr),
        .i_wdata(mem_wdata),
        .o_rdata(mem_rdata)
    );

    assign o_left_data = st_reg.p[0].dout;
    assign o_left_data_oe_n = st_reg.p[0].oe_n;
    assign o_right_data = st_reg.p[1].dout;
    assign o_right_data_oe_n = st_reg.p[1].oe_n;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n || !i_clk_en);

    // left port: the counter branches and the flow-through output path
    sequence clear_seen;
        port_edge[0] && !st_reg.p[0].s3[dpram_pkg::PIN_CLEAR_N];
    endsequence
    sequence load_seen;
        port_edge[0] && st_reg.p[0].s3[dpram_pkg::PIN_CLEAR_N]
            && !st_reg.p[0].s3[dpram_pkg::PIN_STROBE_N];
    endsequence
    sequence step_seen;
        port_edge[0] && st_reg.p[0].s3[dpram_pkg::PIN_CLEAR_N]
            && st_reg.p[0].s3[dpram_pkg::PIN_STROBE_N]
            && !st_reg.p[0].s3[dpram_pkg::PIN_ADVANCE_N];
    endsequence
    sequence ft_read_seen;
        port_edge[0] && !st_reg.p[0].s3[dpram_pkg::PIN_LAT]
            && !st_reg.p[0].s3[dpram_pkg::PIN_CE_N]
            && st_reg.p[0].s3[dpram_pkg::PIN_CE] && st_reg.p[0].s3[dpram_pkg::PIN_RW];
    endsequence

    counter_clear_a: assert property (clear_seen |=> st_reg.p[0].addr == 16'h0000)
        else $error("counter clear did not zero the address");
    address_load_a: assert property (load_seen
        |=> st_reg.p[0].addr == $past(st_reg.p[0].s3[dpram_pkg::PIN_ADDR_LSB +: 16]))
        else $error("address strobe did not load the address");
    counter_step_a: assert property (step_seen
        |=> st_reg.p[0].addr == 16'($past(st_reg.p[0].addr) + 16'h0001))
        else $error("counter did not advance by one");
    address_hold_a: assert property (!port_edge[0] |=> $stable(st_reg.p[0].addr))
        else $error("address moved without a port edge");
    write_edge_a: assert property (mem_we[0] |-> port_edge[0] && !st_reg.p[0].s3[dpram_pkg::PIN_RW])
        else $error("write outside a selected port edge");
    ft_data_a: assert property (ft_read_seen |=> ##1 st_reg.p[0].drive
        && st_reg.p[0].dout == $past(mem_rdata[0]))
        else $error("flow-through read data late");
    deselect_ft_a: assert property (port_edge[0] && !st_reg.p[0].s3[dpram_pkg::PIN_LAT]
        && st_reg.p[0].s3[dpram_pkg::PIN_CE_N] |=> !st_reg.p[0].drive)
        else $error("deselected port still drives");
    oe_gate_a: assert property (st_reg.p[0].s3[dpram_pkg::PIN_OE_N] |=> o_left_data_oe_n)
        else $error("output enable high but pins driven");
    latency_capture_a: assert property (port_edge[0]
        |=> st_reg.p[0].lat == $past(st_reg.p[0].s3[dpram_pkg::PIN_LAT]))
        else $error("latency select not captured");

    // deselection must block the array even while the counter still moves
    desel_write_a: assert property (port_edge[0] && (st_reg.p[0].s3[dpram_pkg::PIN_CE_N]
        || !st_reg.p[0].s3[dpram_pkg::PIN_CE]) |-> !mem_we[0])
        else $error("deselected port wrote the array");
    desel_ce_a: assert property (port_edge[0] && !st_reg.p[0].s3[dpram_pkg::PIN_LAT]
        && !st_reg.p[0].s3[dpram_pkg::PIN_CE] |=> !st_reg.p[0].drive)
        else $error("port with enable low still drives");
    write_data_a: assert property (mem_we[0]
        |-> mem_wdata[0] == st_reg.p[0].s3[dpram_pkg::PIN_DATA_LSB +: 8]
        && mem_addr[0] == st_next.p[0].addr)
        else $error("write byte or address not the captured one");

    // a port edge lasts one system cycle, so a slow port clock never writes twice
    edge_on_rise_a: assert property (port_edge[0]
        |-> st_reg.p[0].s3[dpram_pkg::PIN_CLK] && !st_reg.p[0].clk_level)
        else $error("port edge without a clock rise");
    edge_once_a: assert property (port_edge[0] |=> !port_edge[0])
        else $error("one clock rise seen twice");
    data_stands_a: assert property (!port_edge[0] && !st_reg.p[0].rd_pend
        |=> $stable(st_reg.p[0].dout))
        else $error("read data moved between port edges");
    oe_follow_a: assert property (st_next.p[0].drive
        && !st_reg.p[0].s3[dpram_pkg::PIN_OE_N] |=> !o_left_data_oe_n)
        else $error("output enable low but pins released");

    // right port: flow-through first, then pipelined with a short burst
    sequence r_clear_seen;
        port_edge[1] && !st_reg.p[1].s3[dpram_pkg::PIN_CLEAR_N];
    endsequence
    sequence r_load_seen;
        port_edge[1] && st_reg.p[1].s3[dpram_pkg::PIN_CLEAR_N]
            && !st_reg.p[1].s3[dpram_pkg::PIN_STROBE_N];
    endsequence
    sequence r_step_seen;
        port_edge[1] && st_reg.p[1].s3[dpram_pkg::PIN_CLEAR_N]
            && st_reg.p[1].s3[dpram_pkg::PIN_STROBE_N]
            && !st_reg.p[1].s3[dpram_pkg::PIN_ADVANCE_N];
    endsequence
    sequence r_read_seen;
        port_edge[1] && !st_reg.p[1].s3[dpram_pkg::PIN_LAT]
            && !st_reg.p[1].s3[dpram_pkg::PIN_CE_N]
            && st_reg.p[1].s3[dpram_pkg::PIN_CE] && st_reg.p[1].s3[dpram_pkg::PIN_RW];
    endsequence
    sequence r_pipe_seen;
        port_edge[1] && st_reg.p[1].s3[dpram_pkg::PIN_LAT];
    endsequence

    right_clear_a: assert property (r_clear_seen |=> st_reg.p[1].addr == 16'h0000)
        else $error("right counter clear did not zero the address");
    right_load_a: assert property (r_load_seen
        |=> st_reg.p[1].addr == $past(st_reg.p[1].s3[dpram_pkg::PIN_ADDR_LSB +: 16]))
        else $error("right address strobe did not load the address");
    right_step_a: assert property (r_step_seen
        |=> st_reg.p[1].addr == 16'($past(st_reg.p[1].addr) + 16'h0001))
        else $error("right counter did not advance by one");
    right_hold_a: assert property (!port_edge[1] |=> $stable(st_reg.p[1].addr))
        else $error("right address moved without a port edge");
    right_read_a: assert property (r_read_seen |=> ##1 st_reg.p[1].drive
        && st_reg.p[1].dout == $past(mem_rdata[1]))
        else $error("right flow-through read data late");
    right_latency_a: assert property (port_edge[1]
        |=> st_reg.p[1].lat == $past(st_reg.p[1].s3[dpram_pkg::PIN_LAT]))
        else $error("right latency select not captured");

    // the second enable stage: a deselect shows one port edge late
    deselect_pipe_a: assert property (r_pipe_seen
        |=> st_reg.p[1].drive == $past(st_reg.p[1].rd_valid))
        else $error("pipelined enable stage wrong");
    pipe_data_a: assert property (r_pipe_seen
        |=> st_reg.p[1].dout == $past(st_reg.p[1].hold))
        else $error("pipelined read data not one port cycle late");
    right_edge_a: assert property (port_edge[1]
        |-> st_reg.p[1].s3[dpram_pkg::PIN_CLK] && !st_reg.p[1].clk_level)
        else $error("right port edge without a clock rise");
    right_once_a: assert property (port_edge[1] |=> !port_edge[1])
        else $error("right clock rise seen twice");
    right_stands_a: assert property (!port_edge[1] && !st_reg.p[1].rd_pend
        |=> $stable(st_reg.p[1].dout))
        else $error("right read data moved between port edges");
    right_oe_a: assert property (st_next.p[1].drive
        && !st_reg.p[1].s3[dpram_pkg::PIN_OE_N] |=> !o_right_data_oe_n)
        else $error("right output enable low but pins released");

    // both ports reading one cell in the same cycle must see the same byte
    both_read_a: assert property (ft_read_seen ##0 r_read_seen
        ##0 st_next.p[0].addr == st_next.p[1].addr
        |=> ##1 st_reg.p[0].dout == st_reg.p[1].dout)
        else $error("ports read one cell differently");
endmodule

// >>> dv/port_host.sv
// host model for one ram port, pins packed in the core's sampled-pin layout
// assumes a system clock shared with the core; port clock stays low between accesses
`timescale 1ns/1ps
module port_host (
    input wire logic i_ref_clk,
    input wire logic [7:0] i_data,
    input wire logic i_oe_n,
    output logic [32:0] o_pins
);
    // idle: deselected, counter held, clock low
    logic [32:0] p = 33'h0_0000_00EA;
    assign o_pins = p;
    // c = {clear_n, advance_n, strobe_n, oe_n, read_not_write, ce, ce_n}
    // q returns what the port shows just before this edge
    task automatic acc(input logic [6:0] c, input logic [15:0] a, input logic [7:0] d,
                       output logic [8:0] q);
        @(posedge i_ref_clk);
        p[7:1] <= c;
        p[24:9] <= a;
        // a released data line never keeps the old value
        p[32:25] <= c[2] ? ~p[32:25] : d;
        repeat (5) @(posedge i_ref_clk);
        q = {i_oe_n, i_data};
        p[0] <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        p[0] <= 1'b0;
    endtask
endmodule

// >>> dv/tb_sync_dual_port_ram_with_burst_counter.sv
// self-checking bench: two host models drive both ports of the ram core
// assumes the core sees each port as pins on the shared 40 MHz clock
`timescale 1ns/1ps
module tb_sync_dual_port_ram_with_burst_counter;
    localparam logic [6:0] LW = 7'h62, LR = 7'h66, AW = 7'h52, AR = 7'h56, HR = 7'h76;
    localparam logic [6:0] CR = 7'h26, DW = 7'h53, DR = 7'h77, OD = 7'h7E, EL = 7'h74;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [32:0] pl, pr;
    logic [7:0] dl, dr;
    logic oel, oer;
    logic [8:0] q, q2;
    logic [15:0] av [8];
    logic [7:0] dv [8];
    logic [6:0] cs [7];
    logic [15:0] ea [7];
    logic [7:0] mem [logic [15:0]];
    int mismatches = 0, n_tests = 0;
    integer seed = 11;
    initial forever #12.5 i_ref_clk = ~i_ref_clk;
    port_host hl (.i_ref_clk(i_ref_clk), .i_data(dl), .i_oe_n(oel), .o_pins(pl));
    port_host hr (.i_ref_clk(i_ref_clk), .i_data(dr), .i_oe_n(oer), .o_pins(pr));
    dpram_core dut (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_clk_en(1'b1),
        .i_left_port_clock(pl[0]),
        .i_left_chip_enable_active_low(pl[1]),
        .i_left_chip_enable_active_high(pl[2]),
        .i_left_read_not_write(pl[3]),
        .i_left_output_enable_n(pl[4]),
        .i_left_address_strobe_n(pl[5]),
        .i_left_counter_advance_n(pl[6]),
        .i_left_counter_clear_n(pl[7]),
        .i_left_output_latency_select(pl[8]),
        .i_left_address(pl[24:9]),
        .i_left_data(pl[32:25]),
        .o_left_data(dl),
        .o_left_data_oe_n(oel),
        .i_right_port_clock(pr[0]),
        .i_right_chip_enable_active_low(pr[1]),
        .i_right_chip_enable_active_high(pr[2]),
        .i_right_read_not_write(pr[3]),
        .i_right_output_enable_n(pr[4]),
        .i_right_address_strobe_n(pr[5]),
        .i_right_counter_advance_n(pr[6]),
        .i_right_counter_clear_n(pr[7]),
        .i_right_output_latency_select(pr[8]),
        .i_right_address(pr[24:9]),
        .i_right_data(pr[32:25]),
        .o_right_data(dr),
        .o_right_data_oe_n(oer)
    );
    function automatic logic [8:0] rd(input logic [15:0] a);
        return {1'b0, mem[a]};
    endfunction
    task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic test_done;
        if (mismatches == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge i_ref_clk);
        mismatches++;
        test_done();
    end
    initial begin
        repeat (8) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        @(posedge i_ref_clk);
        chk("rst_l", 9'h100, {oel, dl});
        chk("rst_r", 9'h100, {oer, dr});
        // back-to-back random writes left, read back right
        for (int i = 0; i < 8; i++) begin
            av[i] = 16'($random(seed));
            dv[i] = 8'($random(seed));
            hl.acc(LW, av[i], dv[i], q);
            mem[av[i]] = dv[i];
        end
        for (int i = 0; i < 9; i++) begin
            hr.acc(i < 8 ? LR : HR, av[i % 8], 8'h00, q);
            if (i > 0) chk("rd_r", rd(av[i - 1]), q);
        end
        fork
            hl.acc(LR, av[3], 8'h00, q);
            hr.acc(LR, av[3], 8'h00, q2);
        join
        fork
            hl.acc(HR, av[3], 8'h00, q);
            hr.acc(HR, av[3], 8'h00, q2);
        join
        chk("same_l", rd(av[3]), q);
        chk("same_r", rd(av[3]), q2);
        // burst across the top address, with a deselected write inside
        hl.acc(LW, 16'h0001, 8'h5C, q);
        hl.acc(LW, 16'hFFFE, 8'hA1, q);
        hl.acc(AW, 16'h5555, 8'hA2, q);
        hl.acc(AW, 16'h5555, 8'hA3, q);
        hl.acc(DW, 16'h5555, 8'hEE, q);
        hl.acc(AW, 16'h5555, 8'hA4, q);
        mem[16'h0001] = 8'h5C;
        mem[16'hFFFE] = 8'hA1;
        mem[16'hFFFF] = 8'hA2;
        mem[16'h0000] = 8'hA3;
        mem[16'h0002] = 8'hA4;
        cs = '{AR, AR, HR, AR, AR, CR, HR};
        ea = '{16'hFFFE, 16'hFFFF, 16'h0000, 16'h0000, 16'h0001, 16'h0002, 16'h0000};
        hl.acc(LR, 16'hFFFE, 8'h00, q);
        for (int i = 0; i < 7; i++) begin
            hl.acc(cs[i], 16'h1234, 8'h00, q);
            chk("burst", rd(ea[i]), q);
        end
        // output enable cuts the drive mid-read, without a port edge
        hl.acc(OD, 16'h0000, 8'h00, q);
        chk("oe_high", 9'h100, {q[8], 8'h00});
        hl.acc(DR, 16'h0000, 8'h00, q);
        hl.acc(HR, 16'h0000, 8'h00, q);
        chk("desel", 9'h100, {q[8], 8'h00});
        hl.acc(EL, 16'h0000, 8'h00, q);
        hl.acc(HR, 16'h0000, 8'h00, q);
        chk("desel_ce", 9'h100, {q[8], 8'h00});
        // pipelined right port; first access absorbs the mode change
        @(posedge i_ref_clk);
        hr.p[8] <= 1'b1;
        hr.acc(LR, av[1], 8'h00, q);
        hr.acc(LR, av[1], 8'h00, q);
        hr.acc(LR, av[2], 8'h00, q);
        hr.acc(HR, av[2], 8'h00, q);
        chk("pipe", rd(av[1]), q);
        hr.acc(DR, av[2], 8'h00, q);
        hr.acc(HR, av[2], 8'h00, q);
        chk("pipe_desel", rd(av[2]), q);
        hr.acc(HR, av[2], 8'h00, q);
        chk("pipe_off", 9'h100, {q[8], 8'h00});
        hr.acc(CR, 16'h1234, 8'h00, q);
        hr.acc(AR, 16'h1234, 8'h00, q);
        hr.acc(HR, 16'h1234, 8'h00, q);
        chk("pipe_burst0", rd(16'h0000), q);
        hr.acc(HR, 16'h1234, 8'h00, q);
        chk("pipe_burst1", rd(16'h0001), q);
        test_done();
    end
endmodule
